//--- rtl/rafr_receiver.sv
// Rate-adapted 80-bit frame receiver with an AXI4-Lite register slave.
// Contract
// - Hunt for zero octet then one bit.
// - Three consecutive bad patterns end synchronism.
// - Extract and monitor only while synchronized.
// - Start one bit is octet 2 bit 1.
// - One change event per frame, within-frame too.
// - Repeated bits sampled at their last copy.
// - 600 bit/s: six bits, eightfold repetition.
// - 1200 bit/s: twelve bits, fourfold repetition.
// - 2400 bit/s: 24 bits, twofold repetition.
// - Higher rates: 48 bits, no repetition.
// - Six bits per byte, ones above, endian order.
// - Change event reports E, S8, S9, X2; maskable.
// - Host-initiated descriptor bit raises unmaskable event.
// - Abort, dropped word, loss, hold raise error.
// - Lost change or loss information raises overflow.
// - Inversion option inverts the whole stream.
// - Ten octets; zero octet, ones at bit 1.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module rafr_receiver #(
  parameter int LOSS_COUNT = rafr_pkg::LOSS_FRAMES,
  parameter int ZERO_COUNT = rafr_pkg::START_ZEROS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_clk,
  input wire logic line_data,
  input wire logic [rafr_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [rafr_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic frame_synced
);
  import rafr_pkg::*;

  // Refuse counts the counters cannot hold.
  if (LOSS_COUNT < 1 || LOSS_COUNT > 3 || ZERO_COUNT < 1 || ZERO_COUNT > 15) begin : g_check
    $error("rafr_receiver: LOSS_COUNT or ZERO_COUNT out of range.");
  end

  localparam logic [1:0] LOSS_LAST = 2'(LOSS_COUNT - 1); // Bad frames before loss, less one.
  localparam logic [3:0] ZERO_NEED = 4'(ZERO_COUNT); // Zeros that arm the start detector.

  rafr_state_t s_reg; // Registered state of the whole block.
  rafr_state_t s_next; // Next state.
  rafr_line_t line; // Synchronised line bit and its strobe.

  // ****************************************************************
  // Line pin synchroniser
  // ****************************************************************
  rafr_line_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .line_clk(line_clk),
    .line_data(line_data),
    .line(line)
  );

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // A write channel is ready while its half of the write is not yet held and no write response is pending.
  assign awready = ~s_reg.aw_got & ~s_reg.bvalid;
  assign wready = ~s_reg.w_got & ~s_reg.bvalid;
  assign arready = ~s_reg.rvalid;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign frame_synced = (s_reg.rx_state == ST_SYNC);

  // ****************************************************************
  // Next state
  // ****************************************************************
  // Bus slave, register effects and the frame receiver, in one pass.
  always_comb begin
    rafr_events_t ev_set; // Flags raised in this cycle.
    rafr_events_t ev_clr; // Flags cleared by software in this cycle.
    rafr_esx_t esx_w; // Working copy of this frame's E, S and X bits.
    logic abort_cmd; // Fast receive abort written.
    logic bit_v; // Line bit after optional inversion.
    logic err_now; // Current bit breaks the pattern.
    logic keep; // Current data copy is the last of its repetition.
    logic pop; // Receive word is read out.
    logic [3:0] octet; // Octet index from zero.
    logic [2:0] bitn; // Bit index from zero, bit 1 is zero.
    logic [3:0] grp; // Data octet index from zero.
    logic [5:0] dpos; // Data position within the frame.
    logic [5:0] byte_v; // Completed six-bit group.
    logic [1:0] lane; // Byte lane of the group in the word.
    logic fe; // Frame ends with a bad pattern.
    logic chg; // Frame saw a status change.
    s_next = s_reg;
    ev_set = '0;
    ev_clr = '0;
    esx_w = s_reg.esx_cur;
    abort_cmd = 1'b0;
    bit_v = line.value ^ s_reg.ctrl.invert_enable;
    err_now = 1'b0;
    keep = 1'b0;
    pop = 1'b0;
    octet = s_reg.pos[6:3];
    bitn = s_reg.pos[2:0];
    grp = (octet < OCT_E) ? (octet - 4'h1) : (octet - 4'h2);
    dpos = {2'h0, grp} * 6'h06 + {3'h0, bitn} - 6'h01;
    byte_v = '0;
    lane = '0;
    fe = 1'b0;
    chg = 1'b0;

    // Write channels are taken independently of each other.
    if (awvalid && awready) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_got = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end

    // Both halves held: perform the write and answer.
    if (s_reg.aw_got && s_reg.w_got) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if (s_reg.aw_addr == OFF_CTRL) begin
        if (s_reg.w_strb[0]) begin
          s_next.ctrl[7:0] = s_reg.w_data[7:0];
        end
        if (s_reg.w_strb[1]) begin
          s_next.ctrl[9:8] = s_reg.w_data[10:9];
          abort_cmd = s_reg.w_data[CTRL_ABORT];
        end
      end else if (s_reg.aw_addr == OFF_STATUS) begin
        if (s_reg.w_strb[0]) begin
          ev_clr = s_reg.w_data[STAT_EV_LSB +: 5];
        end
      end else if (s_reg.aw_addr == OFF_DESC) begin
        if (s_reg.w_strb[0]) begin
          ev_set.host_initiated_event = s_reg.w_data[DESC_HI];
          if (s_reg.w_data[DESC_HOLD]) begin
            ev_set.error_event = ~s_reg.ctrl.receive_error_mask;
            ev_set.receive_abort_flag = 1'b1;
          end
        end
      end else if (s_reg.aw_addr == OFF_ESX || s_reg.aw_addr == OFF_DATA) begin
        s_next.bresp = RESP_OKAY; // Read-only words ignore writes.
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end

    // Fast abort drops the partial word and flags the abort.
    if (abort_cmd) begin
      ev_set.error_event = ~s_reg.ctrl.receive_error_mask;
      ev_set.receive_abort_flag = 1'b1;
      s_next.acc_cnt = '0;
      s_next.byte_cnt = '0;
      s_next.word = '0;
    end

    // Read channel: one answer at a time, data word read pops it.
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = '0;
      if (araddr == OFF_CTRL) begin
        s_next.rdata[10:0] = {s_reg.ctrl[9:8], 1'b0, s_reg.ctrl[7:0]};
      end else if (araddr == OFF_STATUS) begin
        s_next.rdata[STAT_SYNC] = (s_reg.rx_state == ST_SYNC);
        s_next.rdata[STAT_EV_LSB +: 5] = s_reg.ev;
        s_next.rdata[STAT_DV] = s_reg.rx_full;
      end else if (araddr == OFF_ESX) begin
        s_next.rdata[9:0] = s_reg.esx_report;
      end else if (araddr == OFF_DATA) begin
        s_next.rdata = s_reg.rx_word;
        pop = s_reg.rx_full;
      end else if (araddr == OFF_DESC) begin
        s_next.rdata = '0;
      end else begin
        s_next.rresp = RESP_SLVERR;
      end
    end
    if (pop) begin
      s_next.rx_full = 1'b0;
    end

    // ****************************************************************
    // Frame receiver
    // ****************************************************************
    if (s_reg.ctrl.channel_mode != MODE_RATE_ADAPT) begin
      // Idle channel: back to the hunt with an empty packer.
      s_next.rx_state = ST_HUNT;
      s_next.zero_run = '0;
      s_next.acc_cnt = '0;
      s_next.byte_cnt = '0;
    end else if (line.strobe) begin
      case (s_reg.rx_state)
        ST_HUNT: begin
          // Count zeros; a one after enough of them aligns the frame.
          if (!bit_v) begin
            if (s_reg.zero_run != ZERO_NEED) begin
              s_next.zero_run = s_reg.zero_run + 4'h1;
            end
          end else begin
            s_next.zero_run = '0;
            if (s_reg.zero_run == ZERO_NEED) begin
              s_next.rx_state = ST_SYNC;
              s_next.pos = POS_AFTER_START;
              s_next.err_cnt = '0;
              s_next.frame_err = 1'b0;
              s_next.prev_valid = 1'b0;
              s_next.sa_seen = 1'b0;
              s_next.sb_seen = 1'b0;
              s_next.in_change = 1'b0;
            end
          end
        end
        ST_SYNC: begin
          // Only this state extracts data and checks status and pattern.
          if (octet == 4'h0) begin
            err_now = bit_v;
          end else if (bitn == 3'h0) begin
            err_now = ~bit_v;
          end else if (octet == OCT_E) begin
            esx_w.e[bitn - 3'h1] = bit_v;
          end else if (bitn == 3'h7) begin
            // S1, S3, S6, S8 form the first group; S4, S9 the second.
            if (octet == 4'h1 || octet == 4'h3 || octet == 4'h6 || octet == OCT_SA) begin
              if (s_reg.sa_seen && bit_v != s_reg.esx_cur.first_s_group) begin
                s_next.in_change = 1'b1;
              end
              esx_w.first_s_group = bit_v;
              s_next.sa_seen = 1'b1;
            end else if (octet == 4'h4 || octet == OCT_SB) begin
              if (s_reg.sb_seen && bit_v != s_reg.esx_cur.second_s_group) begin
                s_next.in_change = 1'b1;
              end
              esx_w.second_s_group = bit_v;
              s_next.sb_seen = 1'b1;
            end else if (octet == OCT_X2) begin
              esx_w.x = bit_v;
            end
          end else begin
            // Keep only the last copy of a repeated bit.
            case (s_reg.ctrl.rate_select_field)
              RATE_600: keep = (dpos[2:0] == 3'h7);
              RATE_1200: keep = (dpos[1:0] == 2'h3);
              RATE_2400: keep = dpos[0];
              default: keep = 1'b1;
            endcase
          end

          // Pack kept bits six to a byte, first bit lowest.
          if (keep) begin
            s_next.acc[s_reg.acc_cnt] = bit_v;
            s_next.acc_cnt = s_reg.acc_cnt + 3'h1;
            if (s_reg.acc_cnt == GROUP_LAST) begin
              byte_v = s_next.acc;
              lane = s_reg.ctrl.big_endian ? (LANE_LAST - s_reg.byte_cnt) : s_reg.byte_cnt;
              s_next.word[{lane, 3'h0} +: 8] = {BYTE_FILL, byte_v};
              s_next.acc_cnt = '0;
              s_next.byte_cnt = s_reg.byte_cnt + 2'h1;
              if (s_reg.byte_cnt == LANE_LAST) begin
                if (s_next.rx_full) begin
                  // Holding word not yet read: this word is dropped and not stored.
                  ev_set.error_event = ~s_reg.ctrl.receive_error_mask;
                end else begin
                  // The working word already carries this last byte.
                  s_next.rx_word = s_next.word;
                  s_next.rx_full = 1'b1;
                end
                s_next.word = '0;
              end
            end
          end

          s_next.esx_cur = esx_w;
          s_next.frame_err = s_reg.frame_err | err_now;

          // Frame end: pattern verdict and status change report.
          if (s_reg.pos == FRAME_LAST) begin
            s_next.pos = '0;
            s_next.frame_err = 1'b0;
            fe = s_reg.frame_err | err_now;
            if (!fe) begin
              s_next.err_cnt = '0;
            end else if (s_reg.err_cnt == LOSS_LAST) begin
              s_next.rx_state = ST_HUNT;
              s_next.zero_run = '0;
              ev_set.error_event = ~s_reg.ctrl.receive_error_mask;
              ev_set.overflow_event = s_reg.ev.error_event
                & ~s_reg.ctrl.receive_error_mask;
            end else begin
              s_next.err_cnt = s_reg.err_cnt + 2'h1;
            end
            chg = s_next.in_change | (s_reg.prev_valid && esx_w != s_reg.esx_prev);
            if (chg && !s_reg.ctrl.change_event_mask) begin
              ev_set.frame_change_event = 1'b1;
              s_next.esx_report = esx_w;
              ev_set.overflow_event = ev_set.overflow_event
                | (s_reg.ev.frame_change_event & ~s_reg.ctrl.receive_error_mask);
            end
            s_next.esx_prev = esx_w;
            s_next.prev_valid = 1'b1;
            s_next.in_change = 1'b0;
            s_next.sa_seen = 1'b0;
            s_next.sb_seen = 1'b0;
          end else begin
            s_next.pos = s_reg.pos + 7'h01;
          end
        end
        default: begin
          s_next.rx_state = ST_HUNT;
        end
      endcase
    end

    // Sticky flags: a set in the same cycle as its clear wins.
    s_next.ev = (s_reg.ev & ~ev_clr) | ev_set;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Registers the whole state; synchronous active-low reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= STATE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

//--- rtl/rafr_pkg.sv
// Shared constants, field layouts and state types of the rate-adapted frame receiver.
package rafr_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam int ADDR_W = 5;                        // Byte address bits decoded.
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;   // Channel specification.
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04; // Sync state and sticky events.
  localparam logic [ADDR_W-1:0] OFF_ESX = 5'h08;    // Last reported E, S and X bits.
  localparam logic [ADDR_W-1:0] OFF_DATA = 5'h0C;   // Receive word, read pops it.
  localparam logic [ADDR_W-1:0] OFF_DESC = 5'h10;   // Receive descriptor control bits.
  localparam int CTRL_ABORT = 8;                    // Write-one fast receive abort.
  localparam int DESC_HI = 0;                       // Host-initiated bit.
  localparam int DESC_HOLD = 1;                     // Hold bit.
  localparam int STAT_SYNC = 0;                     // Status bit of the sync state.
  localparam int STAT_EV_LSB = 1;                   // First of five sticky flags.
  localparam int STAT_DV = 6;                       // Receive word waiting.
  localparam logic [1:0] RESP_OKAY = 2'h0;          // Bus answer for a mapped word.
  localparam logic [1:0] RESP_SLVERR = 2'h2;        // Bus answer for an unmapped word.
  localparam logic [1:0] MODE_RATE_ADAPT = 2'h2;    // Channel mode that runs the receiver.

  // ****************************************************************
  // Frame geometry and counts
  // ****************************************************************
  localparam int START_ZEROS = 8;                   // Zeros before the start one bit.
  localparam int LOSS_FRAMES = 3;                   // Bad frames that end synchronism.
  localparam logic [6:0] FRAME_LAST = 7'h4F;        // Last bit position of 80.
  localparam logic [6:0] POS_AFTER_START = 7'h09;   // Position after octet 2 bit 1.
  localparam logic [3:0] OCT_E = 4'h5;              // Octet 6 carries E1 to E7.
  localparam logic [3:0] OCT_X2 = 4'h7;             // Octet 8 carries the second X.
  localparam logic [3:0] OCT_SA = 4'h8;             // Octet 9 carries S8.
  localparam logic [3:0] OCT_SB = 4'h9;             // Octet 10 carries S9.
  localparam logic [1:0] BYTE_FILL = 2'h3;          // Upper two bits of a packed byte.
  localparam logic [2:0] GROUP_LAST = 3'h5;         // Six user bits per byte.
  localparam logic [1:0] LANE_LAST = 2'h3;          // Four bytes per word.

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    RATE_600 = 2'h0,
    RATE_1200 = 2'h1,
    RATE_2400 = 2'h2,
    RATE_FULL = 2'h3
  } rafr_rate_t;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b01,
    ST_SYNC = 2'b10
  } rafr_rx_state_t;

  // Channel specification word, top bit first.
  typedef struct packed {
    logic flag_filter_enable;
    logic channel_select;
    logic receive_error_mask;
    logic change_event_mask;
    logic big_endian;
    logic invert_enable;
    rafr_rate_t rate_select_field;
    logic [1:0] channel_mode;
  } rafr_ctrl_t;

  // Sticky flags, top bit first; the lowest sits at status bit 1.
  typedef struct packed {
    logic receive_abort_flag;
    logic overflow_event;
    logic error_event;
    logic host_initiated_event;
    logic frame_change_event;
  } rafr_events_t;

  // Reported frame bits: E1 in bit 0, then first and second S group, then X.
  typedef struct packed {
    logic x;
    logic second_s_group;
    logic first_s_group;
    logic [6:0] e;
  } rafr_esx_t;

  // One received line bit.
  typedef struct packed {
    logic strobe;
    logic value;
  } rafr_line_t;

  // Synchroniser state.
  typedef struct packed {
    logic [1:0] clk_sync;
    logic [1:0] dat_sync;
    logic clk_last;
    rafr_line_t line;
  } rafr_sync_t;

  // Whole receiver state; the sync state sits in the lowest bits.
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    rafr_ctrl_t ctrl;
    rafr_events_t ev;
    rafr_esx_t esx_report;
    rafr_esx_t esx_cur;
    rafr_esx_t esx_prev;
    logic prev_valid;
    logic sa_seen;
    logic sb_seen;
    logic in_change;
    logic [3:0] zero_run;
    logic [6:0] pos;
    logic [1:0] err_cnt;
    logic frame_err;
    logic [5:0] acc;
    logic [2:0] acc_cnt;
    logic [31:0] word;
    logic [1:0] byte_cnt;
    logic [31:0] rx_word;
    logic rx_full;
    rafr_rx_state_t rx_state;
  } rafr_state_t;

  localparam rafr_state_t STATE_RESET =
    rafr_state_t'({{($bits(rafr_state_t) - 2){1'b0}}, ST_HUNT});

endpackage

//--- rtl/rafr_line_sync.sv
// Two-flop synchroniser and bit strobe for the serial line pins.
`timescale 1ns/100ps
module rafr_line_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_clk,
  input wire logic line_data,
  output rafr_pkg::rafr_line_t line
);
  import rafr_pkg::*;

  rafr_sync_t s_reg; // Registered synchroniser state.
  rafr_sync_t s_next; // Next synchroniser state.

  // ****************************************************************
  // Next state
  // ****************************************************************
  // The first flop of each pair feeds only the second; the edge test reads the second.
  always_comb begin
    s_next = s_reg;
    s_next.clk_sync = {s_reg.clk_sync[0], line_clk};
    s_next.dat_sync = {s_reg.dat_sync[0], line_data};
    s_next.clk_last = s_reg.clk_sync[1];
    s_next.line.strobe = s_reg.clk_sync[1] & ~s_reg.clk_last;
    s_next.line.value = s_reg.dat_sync[1];
  end

  // Registers the state; reset clears every flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign line = s_reg.line;
endmodule

//--- dv/rafr_chk.sv
// Bus handshake and sync-state assertions bound to the frame receiver.
`timescale 1ns/100ps
module rafr_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] rresp,
  input wire logic frame_synced
);
  // All checks share the system clock; all but AST_SYNC_RST are disabled during its reset.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_AR_FREE: assert property (arready == !rvalid) else $error("arready not inverse of rvalid");
  AST_R_LAT: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid) else $error("rvalid kept after rready");
  AST_B_LAT: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
    else $error("write answer not two cycles after request");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid && awready)
    else $error("write channel not free after response");
  AST_W_BLOCK: assert property (bvalid |-> !awready && !wready) else $error("write taken in response");
  AST_RRESP: assert property (rvalid |-> rresp == 2'h0 || rresp == 2'h2) else $error("bad rresp code");
  AST_SYNC_RST: assert property (disable iff (1'b0) !aresetn |=> !frame_synced)
    else $error("synced during reset");
  AST_SYNC_HOLD: assert property ($rose(frame_synced) |=> frame_synced [*8])
    else $error("sync lost too early");
endmodule
bind rafr_receiver rafr_chk u_rafr_chk (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rresp(rresp),
  .frame_synced(frame_synced));

//--- dv/rafr_line_model.sv
// Serial line source that shifts rate-adapted frames into the receiver.
`timescale 1ns/100ps
module rafr_line_model (
  input wire logic aclk,
  output logic line_clk,
  output logic line_data
);
  // The line clock stands low between frames.
  initial begin
    line_clk = 1'b0;
    line_data = 1'b1;
  end
  // Shifts one frame out, index 0 first; data changes only while the clock is low.
  task automatic send(input logic [79:0] f);
    for (int i = 0; i < 80; i++) begin
      line_data <= f[i];
      repeat (4) @(posedge aclk);
      line_clk <= 1'b1;
      repeat (4) @(posedge aclk);
      line_clk <= 1'b0;
    end
    line_data <= ~f[79];
    @(posedge aclk);
  endtask
endmodule

//--- dv/rate_adapted_frame_receiver_tb_top.sv
// Self-checking bench of the rate-adapted frame receiver.
`timescale 1ns/100ps
module rate_adapted_frame_receiver_tb_top;
  import rafr_pkg::*;
  localparam logic [47:0] USR = 48'hA5C3_96F0_1E7B; // User bit stream, first bit at 0.
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, frame_synced, line_clk, line_data;
  logic [1:0] bresp, rresp, rd_r;
  int mismatches = 0, samples_checked = 0;
  rafr_receiver u_rafr_receiver (.aclk(aclk), .aresetn(aresetn), .line_clk(line_clk),
    .line_data(line_data), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .frame_synced(frame_synced));
  rafr_line_model u_rafr_line_model (.aclk(aclk), .line_clk(line_clk), .line_data(line_data));
  initial forever #50 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Write: both halves offered together, each dropped once its ready was seen.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      if (awready) pa = 1'b0;
      if (wready) pw = 1'b0;
      @(posedge aclk);
      awvalid <= pa;
      wvalid <= pw;
    end while (pa || pw);
    do @(negedge aclk); while (!bvalid);
    rd_r = bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [4:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    rd_v = rdata;
    rd_r = rresp;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_v & m, e);
  endtask
  // Builds one frame: rate r, user bits u, E/S/X word e, optional pattern error.
  function automatic logic [79:0] mk(input int r, input logic [47:0] u, input logic [9:0] e,
                                     input bit bad);
    logic [79:0] f;
    int o, b, p, rep;
    rep = 8 >> r;
    p = 0;
    for (int i = 0; i < 80; i++) begin
      o = i / 8;
      b = i % 8;
      if (o == 0) f[i] = 1'b0;
      else if (b == 0) f[i] = 1'b1;
      else if (o == 5) f[i] = e[b - 1];
      else if (b == 7) f[i] = (o == 4 || o == 9) ? e[8] : (o == 2 || o == 7) ? e[9] : e[7];
      else begin
        f[i] = u[p / rep] ^ (p % rep != rep - 1);
        p++;
      end
    end
    f[3] = f[3] ^ bad;
    return f;
  endfunction
  function automatic logic [31:0] pack(input bit big);
    logic [31:0] w;
    for (int g = 0; g < 4; g++) w[8 * (big ? 3 - g : g) +: 8] = {2'b11, USR[6 * g +: 6]};
    return w;
  endfunction
  task automatic t_regs();
    rc(OFF_CTRL, 32'hFFFFFFFF, 32'h0);
    rc(OFF_STATUS, 32'hFFFFFFFF, 32'h0);
    rd(5'h14);
    chk(rd_r, RESP_SLVERR);
    wr(5'h14, 32'hFFFFFFFF);
    chk(rd_r, RESP_SLVERR);
  endtask
  task automatic t_desc();
    wr(OFF_CTRL, 32'hC0);
    wr(OFF_DESC, 32'h3);
    rc(OFF_STATUS, 32'h3E, 32'h24);
    wr(OFF_STATUS, 32'h3E);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'h100);
    rc(OFF_STATUS, 32'h3E, 32'h28);
  endtask
  task automatic t_esx_loss();
    logic [9:0] e [4] = '{10'h155, 10'h2AA, 10'h0F0, 10'h30F};
    wr(OFF_CTRL, 32'h2);
    for (int k = 0; k < 2; k++) u_rafr_line_model.send(mk(0, USR, e[k], 1'b0));
    rc(OFF_STATUS, 32'h13, 32'h03);
    rc(OFF_ESX, 32'h3FF, {22'h0, e[1]});
    u_rafr_line_model.send(mk(0, USR, e[2], 1'b0));
    rc(OFF_STATUS, 32'h10, 32'h10);
    wr(OFF_STATUS, 32'h3E);
    wr(OFF_CTRL, 32'h42);
    u_rafr_line_model.send(mk(0, USR, e[3], 1'b0));
    rc(OFF_STATUS, 32'h02, 32'h0);
    wr(OFF_CTRL, 32'h2);
    // Only S1 is flipped, so just the within-frame test can see a change.
    u_rafr_line_model.send(mk(0, USR, e[3], 1'b0) ^ (80'h1 << 15));
    rc(OFF_STATUS, 32'h12, 32'h02);
    for (int k = 0; k < 5; k++) u_rafr_line_model.send(mk(0, USR, e[3], k != 2));
    chk(frame_synced, 32'h1);
    wr(OFF_STATUS, 32'h3E);
    rd(OFF_DATA);
    u_rafr_line_model.send(mk(0, USR, e[3], 1'b1));
    chk(frame_synced, 32'h0);
    rc(OFF_STATUS, 32'h08, 32'h08);
  endtask
  task automatic t_rates();
    for (int r = 0; r < 4; r++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_STATUS, 32'h3E);
      wr(OFF_CTRL, {26'h0, r[0], r == 2, r[1:0], 2'h2});
      for (int k = 0; k < ((r == 3) ? 1 : 4 >> r); k++)
        u_rafr_line_model.send(mk(r, USR >> (k * (6 << r)), 10'h0, 1'b0) ^ {80{r == 2}});
      chk(frame_synced, 32'h1);
      rc(OFF_STATUS, 32'h4A, (r == 3) ? 32'h48 : 32'h40);
      rc(OFF_DATA, 32'hFFFFFFFF, pack(r[0]));
    end
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_desc();
    t_esx_loss();
    t_rates();
    final_report();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (40000) @(posedge aclk);
    mismatches++;
    final_report();
  end
endmodule
